/* File: tcs_timer_pair.sv */
// Two counter/timers, shared prescaler, clock-select and register slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_pair
  import tcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_zero_event_pin,
  input wire logic timer_one_event_pin,
  input wire logic ext_irq_zero_input,
  input wire logic ext_irq_one_input,
  input wire logic ext_clock_pin,
  input wire logic timer_zero_irq_ack,
  input wire logic timer_one_irq_ack,
  output logic timer_zero_irq,
  output logic timer_one_irq,
  output logic timer_zero_overflow,
  output logic timer_one_overflow,
  output logic timer_two_low_tick,
  output logic timer_two_high_tick,
  output logic timer_three_low_tick,
  output logic timer_three_high_tick
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] timer_control_register;
  logic [7:0] timer_mode_register;
  logic [7:0] timer_clock_select;
  logic [7:0] ext_irq_config;
  logic [7:0] aux_config;
  logic [7:0] t0_low, t0_high, t1_low, t1_high;
  logic t0_ovf_low, t0_ovf_high, t1_ovf_low;

  // ----------------------------------------------------------------
  // Pin synchronisers: two flops, then a third for edge detection
  // ----------------------------------------------------------------
  logic [4:0] pin_meta, pin_sync, pin_last;
  wire logic [4:0] pins = {ext_clock_pin, ext_irq_one_input, ext_irq_zero_input,
                           timer_one_event_pin, timer_zero_event_pin};

  // Only pin_sync reads pin_meta
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_last <= 5'h00;
    end else begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // A level shorter than one clock may be missed entirely
  wire logic t0_fall = pin_last[0] & ~pin_sync[0];
  wire logic t1_fall = pin_last[1] & ~pin_sync[1];
  wire logic ext_rise = pin_sync[4] & ~pin_last[4];

  // ----------------------------------------------------------------
  // Prescaler: one free counter serves all three system divisions
  // ----------------------------------------------------------------
  logic [PRE_W-1:0] pre_cnt;
  logic [EXT_W-1:0] ext_cnt;
  wire logic pre_wrap = (int'(pre_cnt) == DIV_LONG - 1);
  wire logic tick12 = ((int'(pre_cnt) % DIV_SLOW) == DIV_SLOW - 1);
  wire logic tick4 = ((int'(pre_cnt) % DIV_FAST) == DIV_FAST - 1);
  wire logic ext8 = ext_rise & (int'(ext_cnt) == DIV_EXT - 1);
  wire logic [1:0] sca = timer_clock_select[1:0];
  wire logic presc = (sca == SCA_DIV12) ? tick12 :
                     (sca == SCA_DIV4) ? tick4 :
                     (sca == SCA_DIV48) ? pre_wrap : ext8;

  // Divider counters; the external one advances per synced rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= '0;
      ext_cnt <= '0;
    end else begin
      pre_cnt <= pre_wrap ? '0 : pre_cnt + PRE_W'(1);
      if (ext_rise) ext_cnt <= ext_cnt + EXT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Run, gate and count-enable selection
  // ----------------------------------------------------------------
  wire logic [1:0] mode0 = timer_mode_register[1:0];
  wire logic [1:0] mode1 = timer_mode_register[MD_T1_LSB+1:MD_T1_LSB];
  wire logic ct0 = timer_mode_register[MD_COUNTER];
  wire logic timer_zero_gating = timer_mode_register[MD_GATE];
  wire logic ct1 = timer_mode_register[MD_T1_LSB+MD_COUNTER];
  wire logic timer_one_gating = timer_mode_register[MD_T1_LSB+MD_GATE];
  wire logic tr0 = timer_control_register[CT_T0_RUN];
  wire logic tr1 = timer_control_register[CT_T1_RUN];
  wire logic tf0 = timer_control_register[CT_T0_FLAG];
  wire logic tf1 = timer_control_register[CT_T1_FLAG];
  wire logic t0split = (mode0 == TCS_MSPLIT);
  wire logic ext_irq_zero_input_act = (pin_sync[2] == ext_irq_config[IC_POL0]);
  wire logic ext_irq_one_input_act = (pin_sync[3] == ext_irq_config[IC_POL1]);
  wire logic t0_int = timer_clock_select[CS_T0_SYS] | presc;
  wire logic t1_int = timer_clock_select[CS_T1_SYS] | presc;
  wire logic run0 = tr0 & (~timer_zero_gating | ext_irq_zero_input_act);
  wire logic run1 = (mode1 != TCS_MSPLIT) & (t0split | (tr1 & (~timer_one_gating | ext_irq_one_input_act)));
  wire logic t0_inc_low = run0 & (ct0 ? t0_fall : t0_int);
  wire logic t0_inc_high = t0split & tr1 & t0_int;
  wire logic t1_inc_low = run1 & ((ct1 & ~t0split) ? t1_fall : t1_int);

  // ----------------------------------------------------------------
  // Timer cores
  // ----------------------------------------------------------------
  logic wr_en;
  logic [IDX_W-1:0] w_idx;
  logic [7:0] w_byte;

  tcs_timer_core u_timer_zero (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode0),
    .inc_low(t0_inc_low),
    .inc_high(t0_inc_high),
    .wr_low(wr_en && w_idx == IDX_T0_LOW),
    .wr_high(wr_en && w_idx == IDX_T0_HIGH),
    .wdata(w_byte),
    .low(t0_low),
    .high(t0_high),
    .ovf_low(t0_ovf_low),
    .ovf_high(t0_ovf_high)
  );

  // Timer one never splits, so its high-byte increment is tied off
  tcs_timer_core u_timer_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode1),
    .inc_low(t1_inc_low),
    .inc_high(1'b0),
    .wr_low(wr_en && w_idx == IDX_T1_LOW),
    .wr_high(wr_en && w_idx == IDX_T1_HIGH),
    .wdata(w_byte),
    .low(t1_low),
    .high(t1_high),
    .ovf_low(t1_ovf_low),
    .ovf_high()
  );

  // ----------------------------------------------------------------
  // Overflow flags: hardware set wins over software or vector clear
  // ----------------------------------------------------------------
  wire logic wr_ctrl = wr_en && (w_idx == IDX_CONTROL);
  wire logic set_tf0 = t0_ovf_low;
  wire logic set_tf1 = t0split ? t0_ovf_high : t1_ovf_low;
  wire logic next_tf0 = set_tf0 | (wr_ctrl ? w_byte[CT_T0_FLAG] : (tf0 & ~timer_zero_irq_ack));
  wire logic next_tf1 = set_tf1 | (wr_ctrl ? w_byte[CT_T1_FLAG] : (tf1 & ~timer_one_irq_ack));
  wire logic [7:0] next_ctrl = {next_tf1,
                                wr_ctrl ? w_byte[CT_T1_RUN] : tr1,
                                next_tf0,
                                wr_ctrl ? w_byte[CT_T0_RUN] : tr0,
                                wr_ctrl ? w_byte[3:0] : timer_control_register[3:0]};

  // Control and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_register <= RST_BYTE;
      timer_mode_register <= RST_BYTE;
      timer_clock_select <= RST_BYTE;
      ext_irq_config <= RST_BYTE;
      aux_config <= RST_BYTE;
    end else begin
      timer_control_register <= next_ctrl;
      if (wr_en && w_idx == IDX_MODE) timer_mode_register <= w_byte;
      if (wr_en && w_idx == IDX_CLK_SEL) timer_clock_select <= w_byte;
      if (wr_en && w_idx == IDX_IRQ_CFG) ext_irq_config <= w_byte;
      if (wr_en && w_idx == IDX_AUX) aux_config <= w_byte;
    end
  end

  // ----------------------------------------------------------------
  // Clock enables for the two auto-reload timers
  // ----------------------------------------------------------------
  wire logic t2_own = aux_config[AX_T2_EXT] ? ext8 : tick12;
  wire logic t3_own = aux_config[AX_T3_EXT] ? ext8 : tick12;
  wire logic next_t2l = timer_clock_select[CS_T2_LOW] | t2_own;
  wire logic next_t2h = aux_config[AX_T2_SPLIT] & (timer_clock_select[CS_T2_HIGH] | t2_own);
  wire logic next_t3l = timer_clock_select[CS_T3_LOW] | t3_own;
  wire logic next_t3h = aux_config[AX_T3_SPLIT] & (timer_clock_select[CS_T3_HIGH] | t3_own);

  // Ticks and overflow pulses leave through flops, one cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_two_low_tick <= 1'b0;
      timer_two_high_tick <= 1'b0;
      timer_three_low_tick <= 1'b0;
      timer_three_high_tick <= 1'b0;
      timer_zero_overflow <= 1'b0;
      timer_one_overflow <= 1'b0;
    end else begin
      timer_two_low_tick <= next_t2l;
      timer_two_high_tick <= next_t2h;
      timer_three_low_tick <= next_t3l;
      timer_three_high_tick <= next_t3h;
      timer_zero_overflow <= t0_ovf_low;
      timer_one_overflow <= t1_ovf_low;
    end
  end

  assign timer_zero_irq = tf0 & aux_config[AX_IEN0];
  assign timer_one_irq = tf1 & aux_config[AX_IEN1];

  // ----------------------------------------------------------------
  // AXI4-Lite slave: address and data latched independently
  // ----------------------------------------------------------------
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign w_idx = aw_addr[ADDR_W-1:2];
  wire logic do_write = aw_held & w_held & ~s_axi_bvalid;
  logic w_lane0;
  assign wr_en = do_write & w_lane0;
  wire logic [IDX_W-1:0] r_idx = s_axi_araddr[ADDR_W-1:2];

  // Unmapped addresses answer SLVERR and change nothing
  wire logic w_mapped = (w_idx == IDX_CONTROL) || (w_idx == IDX_MODE) || (w_idx == IDX_CLK_SEL) ||
                        (w_idx == IDX_IRQ_CFG) || (w_idx == IDX_AUX) || (w_idx == IDX_T0_LOW) ||
                        (w_idx == IDX_T0_HIGH) || (w_idx == IDX_T1_LOW) || (w_idx == IDX_T1_HIGH);
  logic [7:0] r_byte;
  logic r_mapped;
  always_comb begin
    r_mapped = 1'b1;
    if (r_idx == IDX_CONTROL) r_byte = timer_control_register;
    else if (r_idx == IDX_MODE) r_byte = timer_mode_register;
    else if (r_idx == IDX_CLK_SEL) r_byte = timer_clock_select;
    else if (r_idx == IDX_IRQ_CFG) r_byte = ext_irq_config;
    else if (r_idx == IDX_AUX) r_byte = aux_config;
    else if (r_idx == IDX_T0_LOW) r_byte = t0_low;
    else if (r_idx == IDX_T0_HIGH) r_byte = t0_high;
    else if (r_idx == IDX_T1_LOW) r_byte = t1_low;
    else if (r_idx == IDX_T1_HIGH) r_byte = t1_high;
    else begin
      r_byte = 8'h00;
      r_mapped = 1'b0;
    end
  end

  // Write channel latches and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data registered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, r_byte};
      s_axi_rresp <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_tf0 || set_tf1) |=> (!$past(set_tf0) || tf0) && (!$past(set_tf1) || tf1))
    else $error("overflow did not set its flag");
  AST_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tr0 || (timer_zero_gating && !ext_irq_zero_input_act)) |-> !t0_inc_low)
    else $error("timer zero counted while disabled");
  AST_T1_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode1 == TCS_MSPLIT) |-> !t1_inc_low && !t1_ovf_low)
    else $error("timer one counted in mode 3");
  AST_SPLIT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    (t0split && !t0_ovf_high && !wr_ctrl && !tf1) |=> !tf1)
    else $error("timer one flag set while timer zero split");
  AST_SYS_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    (run0 && !ct0 && timer_clock_select[CS_T0_SYS]) |-> t0_inc_low)
    else $error("system clock select did not count every cycle");
  AST_EXT_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (run0 && ct0) |-> (t0_inc_low == t0_fall))
    else $error("counter mode not tied to event pin falls");
  AST_T2_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_clock_select[CS_T2_LOW] |=> timer_two_low_tick)
    else $error("timer two low tick missing with system clock select");

endmodule
`default_nettype wire

/* File: tcs_pkg.sv */
// Constants shared by the dual timer/counter and clock-select block
package tcs_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h088;
  localparam logic [IDX_W-1:0] IDX_MODE = 10'h089;
  localparam logic [IDX_W-1:0] IDX_T0_LOW = 10'h08A;
  localparam logic [IDX_W-1:0] IDX_T1_LOW = 10'h08B;
  localparam logic [IDX_W-1:0] IDX_T0_HIGH = 10'h08C;
  localparam logic [IDX_W-1:0] IDX_T1_HIGH = 10'h08D;
  localparam logic [IDX_W-1:0] IDX_CLK_SEL = 10'h08E;
  localparam logic [IDX_W-1:0] IDX_IRQ_CFG = 10'h090;
  localparam logic [IDX_W-1:0] IDX_AUX = 10'h091;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Control register
  localparam int CT_T1_FLAG = 7;
  localparam int CT_T1_RUN = 6;
  localparam int CT_T0_FLAG = 5;
  localparam int CT_T0_RUN = 4;
  // Mode register: timer zero in the low nibble, timer one in the high
  localparam int MD_T1_LSB = 4;
  localparam int MD_COUNTER = 2;
  localparam int MD_GATE = 3;
  // Clock-select register
  localparam int CS_T0_SYS = 2;
  localparam int CS_T1_SYS = 3;
  localparam int CS_T2_LOW = 4;
  localparam int CS_T2_HIGH = 5;
  localparam int CS_T3_LOW = 6;
  localparam int CS_T3_HIGH = 7;
  // Interrupt configuration and auxiliary register
  localparam int IC_POL0 = 0;
  localparam int IC_POL1 = 1;
  localparam int AX_IEN0 = 0;
  localparam int AX_IEN1 = 1;
  localparam int AX_T2_EXT = 2;
  localparam int AX_T3_EXT = 3;
  localparam int AX_T2_SPLIT = 4;
  localparam int AX_T3_SPLIT = 5;

  // ----------------------------------------------------------------
  // Modes and dividers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCS_M13 = 2'h0,
    TCS_M16 = 2'h1,
    TCS_MRELOAD = 2'h2,
    TCS_MSPLIT = 2'h3
  } tcs_mode_t;

  localparam logic [1:0] SCA_DIV12 = 2'h0;
  localparam logic [1:0] SCA_DIV4 = 2'h1;
  localparam logic [1:0] SCA_DIV48 = 2'h2;
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  localparam int DIV_LONG = 48;
  localparam int DIV_EXT = 8;
  localparam int PRE_W = $clog2(DIV_LONG);
  localparam int EXT_W = $clog2(DIV_EXT);

endpackage

/* File: tcs_timer_core.sv */
// One 16-bit timer register pair with its four counting modes
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_core
  import tcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode,
  input wire logic inc_low,
  input wire logic inc_high,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  output logic [7:0] low,
  output logic [7:0] high,
  output logic ovf_low,
  output logic ovf_high
);

  // ----------------------------------------------------------------
  // Wrap detection
  // ----------------------------------------------------------------
  wire logic m13 = (mode == TCS_M13);
  wire logic m16 = (mode == TCS_M16);
  wire logic mrl = (mode == TCS_MRELOAD);
  wire logic msp = (mode == TCS_MSPLIT);
  wire logic all13 = &{high, low[4:0]};
  wire logic all16 = &{high, low};
  wire logic all_lo = &low;
  wire logic all_hi = &high;

  // Overflow is an increment that wraps the active count
  assign ovf_low = inc_low & (m13 ? all13 : (m16 ? all16 : all_lo));
  assign ovf_high = inc_high & msp & all_hi;

  // ----------------------------------------------------------------
  // Next values; a software write wins over a same-cycle increment
  // ----------------------------------------------------------------
  // Bits 7..5 are left alone in 13-bit mode; readers must ignore them
  wire logic [7:0] low_inc = m13 ? {low[7:5], low[4:0] + 5'h01} : low + 8'h01;
  wire logic [7:0] next_low = wr_low ? wdata :
                              !inc_low ? low :
                              (mrl && all_lo) ? high : low_inc;
  wire logic carry = inc_low & ((m13 & (&low[4:0])) | (m16 & all_lo));
  wire logic [7:0] next_high = wr_high ? wdata :
                               (carry || (msp && inc_high)) ? high + 8'h01 : high;

  // Count holds its value unless written or ticked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low <= RST_BYTE;
      high <= RST_BYTE;
    end else begin
      low <= next_low;
      high <= next_high;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (mrl && inc_low && all_lo && !wr_low && !wr_high) |=> (low == $past(high)) && $stable(high))
    else $error("reload byte not copied into low byte");
  AST_WRAP16: assert property (@(posedge aclk) disable iff (!aresetn)
    (m16 && inc_low && all16 && !wr_low && !wr_high) |-> ovf_low ##1 ({high, low} == 16'h0000))
    else $error("16-bit wrap did not reach zero with overflow");
  AST_WRAP13: assert property (@(posedge aclk) disable iff (!aresetn)
    (m13 && ovf_low && !wr_low && !wr_high) |=> ({high, low[4:0]} == 13'h0000))
    else $error("13-bit overflow without wrap to zero");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (!inc_low && !inc_high && !wr_low && !wr_high) |=> $stable(low) && $stable(high))
    else $error("count moved without tick or write");

endmodule
`default_nettype wire

/* File: tcs_event_src.sv */
// Model of the pins beside the timers: event pins, gate inputs, external clock
`timescale 1ns/1ps
`default_nettype none
module tcs_event_src (
  input wire logic aclk,
  output logic ev0,
  output logic ev1,
  output logic irq0,
  output logic irq1,
  output logic ext_clk
);
  initial begin
    {ev0, ev1, irq0, irq1, ext_clk} = 5'h18;
  end
  // One falling edge; each level stands three clocks so the sampler never misses it
  task automatic fall(input bit one);
    repeat (3) @(posedge aclk);
    if (one) ev1 <= 1'b0; else ev0 <= 1'b0;
    repeat (3) @(posedge aclk);
    {ev0, ev1} <= 2'h3;
    repeat (6) @(posedge aclk);
  endtask
  // Eight rising edges on the external clock; each level stands three clocks
  task automatic clk8;
    repeat (16) begin
      repeat (3) @(posedge aclk);
      ext_clk <= ~ext_clk;
    end
  endtask
  task automatic gate(input bit v);
    @(posedge aclk);
    irq1 <= v;
  endtask
endmodule
`default_nettype wire

/* File: test_dual_timer_counter_clock_select.sv */
// Self-checking bench for the dual timer pair and clock select
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_counter_clock_select;
  import tcs_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, ack0 = 0, ack1 = 0, timer_one_irq;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ev0, ev1, irq0, irq1, xclk, timer_zero_irq, timer_zero_overflow, timer_one_overflow, timer_two_low_tick;
  int err_total = 0, samples_checked = 0;
  always #2.5 aclk = ~aclk;
  tcs_event_src tcs_event_src_i (.aclk, .ev0, .ev1, .irq0, .irq1, .ext_clk(xclk));
  tcs_timer_pair tcs_timer_pair_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_zero_event_pin(ev0),
    .timer_one_event_pin(ev1), .ext_irq_zero_input(irq0), .ext_irq_one_input(irq1), .ext_clock_pin(xclk),
    .timer_zero_irq_ack(ack0), .timer_one_irq_ack(ack1), .timer_zero_irq, .timer_one_irq,
    .timer_zero_overflow, .timer_one_overflow, .timer_two_low_tick, .timer_two_high_tick(),
    .timer_three_low_tick(), .timer_three_high_tick());
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [IDX_W-1:0] what, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR item %h expected %h seen %h", what, e, g);
    end
  endtask
  // Either channel may be taken first, so each is dropped on its own ready;
  // readies are sampled mid-cycle so they are the values the next edge sees
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    logic a, w, b;
    logic [1:0] resp;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {i, 2'h0, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      {a, w, b, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin err_total++; results(); end
    chk(i, {r, 32'h0}, {resp, 32'h0});
  endtask
  task automatic rd(input logic [IDX_W-1:0] i, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    int n;
    logic a, v;
    logic [33:0] g;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      {a, v, g} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (v) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) begin err_total++; results(); end
    chk(i, {r, 24'h0, e}, g);
  endtask
  // Bounded wait: 0 timer zero pulse, 1 timer one pulse, 2 timer one interrupt
  task automatic wait_ovf(input int s);
    int n;
    logic [2:0] v;
    for (n = 0; n < 1000; n++) begin
      @(negedge aclk);
      v = {timer_one_irq, timer_one_overflow, timer_zero_overflow};
      if (v[s]) break;
    end
    if (n == 1000) begin err_total++; results(); end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CLK_SEL, 8'h00);
    rd(10'h3FF, 8'h00, RESP_SLVERR);
    wr(IDX_CLK_SEL, 8'h10);
    repeat (2) @(posedge aclk);
    chk(0, 34'h1, {33'h0, timer_two_low_tick});
    // A write with no byte lane enabled is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    wr(IDX_CLK_SEL, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(IDX_CLK_SEL, 8'h10);
    wr(10'h3FF, 8'h00, RESP_SLVERR);
    // Reload mode fed by event pin edges
    wr(IDX_MODE, 8'h06);
    wr(IDX_T0_LOW, 8'hFF);
    wr(IDX_T0_HIGH, 8'hA5);
    wr(IDX_AUX, 8'h01);
    wr(IDX_CONTROL, 8'h10);
    rd(IDX_T0_LOW, 8'hFF);
    tcs_event_src_i.fall(0);
    rd(IDX_T0_LOW, 8'hA5);
    rd(IDX_T0_HIGH, 8'hA5);
    rd(IDX_CONTROL, 8'h30);
    chk(1, 34'h1, {33'h0, timer_zero_irq});
    ack0 <= 1'b1;
    @(posedge aclk);
    ack0 <= 1'b0;
    rd(IDX_CONTROL, 8'h10);
    // 13-bit wrap from all ones
    wr(IDX_MODE, 8'h04);
    wr(IDX_T0_HIGH, 8'hFF);
    wr(IDX_T0_LOW, 8'h1F);
    tcs_event_src_i.fall(0);
    rd(IDX_T0_HIGH, 8'h00);
    rd(IDX_T0_LOW, 8'h00);
    rd(IDX_CONTROL, 8'h30);
    // Timer one gated by the second input, active high
    wr(IDX_MODE, 8'hD4);
    wr(IDX_IRQ_CFG, 8'h02);
    wr(IDX_CONTROL, 8'h40);
    tcs_event_src_i.fall(1);
    rd(IDX_T1_LOW, 8'h00);
    tcs_event_src_i.gate(1);
    tcs_event_src_i.fall(1);
    rd(IDX_T1_LOW, 8'h01);
    // 16-bit timer on the system clock
    wr(IDX_MODE, 8'h01);
    wr(IDX_CLK_SEL, 8'h04);
    wr(IDX_T0_HIGH, 8'hFF);
    wr(IDX_T0_LOW, 8'hF0);
    wr(IDX_CONTROL, 8'h10);
    wait_ovf(0);
    rd(IDX_CONTROL, 8'h30);
    // Split: timer one runs on its mode alone, pulses but never flags
    wr(IDX_MODE, 8'h13);
    wr(IDX_CLK_SEL, 8'h0C);
    wr(IDX_AUX, 8'h03);
    wr(IDX_T1_HIGH, 8'hFF);
    wr(IDX_T1_LOW, 8'hF0);
    wait_ovf(1);
    rd(IDX_CONTROL, 8'h30);
    // Split high byte runs on timer one's run bit and flag
    wr(IDX_T0_HIGH, 8'hF0);
    wr(IDX_CONTROL, 8'h40);
    wait_ovf(2);
    rd(IDX_CONTROL, 8'hC0);
    ack1 <= 1'b1;
    @(posedge aclk);
    ack1 <= 1'b0;
    rd(IDX_CONTROL, 8'h40);
    // External clock prescale: eight rising edges make one count
    wr(IDX_MODE, 8'h01);
    wr(IDX_CLK_SEL, 8'h03);
    wr(IDX_T0_LOW, 8'h00);
    wr(IDX_CONTROL, 8'h10);
    tcs_event_src_i.clk8();
    rd(IDX_T0_LOW, 8'h01);
    results();
  end
endmodule
`default_nettype wire
